// ==== inc/cscr_pkg.sv ====
// Package of offsets, field positions, reset values, timing and types for the converter register bank
package cscr_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_COND   = 8'h0A;
  localparam logic [7:0] ADDR_DEVCTL = 8'h0B;
  localparam logic [7:0] ADDR_CHGCFG = 8'h0C;
  // converter_condition fields
  localparam int COND_THERM_FLAG = 7;
  localparam int COND_THERM_LIVE = 6;
  localparam int COND_LOW_LIVE   = 5;
  localparam int COND_HIGH_LIVE  = 4;
  localparam int COND_SS_FLAG    = 3;
  localparam int COND_RUN_LIVE   = 2;
  localparam int COND_OCP_FLAG   = 1;
  localparam int COND_DIAG_FLAG  = 0;
  // device_control fields
  localparam int DEVCTL_REG_RST = 7;
  localparam int DEVCTL_FSW_LSB = 4;
  localparam int DEVCTL_WD_FLAG = 3;
  localparam int DEVCTL_WD_OFF  = 2;
  localparam int DEVCTL_WD_LSB  = 0;
  // charge_config fields
  localparam int CHG_ON_BIT     = 7;
  localparam int CHG_ROLE_LSB   = 5;
  localparam int CHG_DITHER_LSB = 3;
  localparam int CHG_GUARD_LSB  = 0;
  // Reset values, frequency cap and standalone role code
  localparam logic [7:0] DEVCTL_RESET = 8'h40;
  localparam logic [7:0] CHGCFG_RESET = 8'h00;
  localparam logic [2:0] FSW_CAP      = 3'h4;
  localparam logic [1:0] ROLE_ALONE   = 2'h0;
  // Timing
  localparam int CLK_KHZ      = 50000;
  localparam int WD_MS0       = 500;
  localparam int WD_MS1       = 1000;
  localparam int WD_MS2       = 5000;
  localparam int WD_MS3       = 30000;
  localparam int SS_MS0       = 10;
  localparam int SS_MS1       = 20;
  localparam int SS_MS2       = 50;
  localparam int SS_MS3       = 100;
  localparam int INT_PULSE_US = 64;
  localparam int INT_PULSE_CYC = (INT_PULSE_US * CLK_KHZ + 999) / 1000;
  // Types
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cscr_req_s;
  typedef struct packed {
    logic therm;
    logic low;
    logic high;
    logic ocp;
    logic ucp_ok;
    logic diag_fail;
  } cscr_sense_s;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_SOFT = 2'b01,
    CONV_RUN  = 2'b10,
    CONV_HALT = 2'b11
  } cscr_conv_e;
endpackage

// ==== hdl/cscr_top.sv ====
// Converter status and control register bank with link-side register port
//
// Contract
// - Thermal trip event sets flag bit 7, raises interrupt, read clears it.
// - Thermal live bit reads 1 while over-temperature persists.
// - Bit 5 tracks input too low to start switching.
// - Bit 4 tracks input too high to start switching.
// - Soft-start timeout stops switching, sets flag, interrupts; read clears flag.
// - Switching start raises exactly one unmaskable interrupt; running bit always live.
// - Switch current limit sets flag bit 1, interrupts; read clears it.
// - Charge enable write while charging is off runs pin checks; failure sets bit 0 flag, interrupts.
// - Writing register-reset restores defaults except frequency select (takes written field) and soft-start/current limit flags (kept); the bit reads 0.
// - Three-bit frequency select chooses switching rate, default 500 kHz.
// - Master or slave role caps switching frequency at 500 kHz.
// - Watchdog expiry sets flag bit 3, interrupts; read clears it.
// - Watchdog off bit disables watchdog when 1; resets to 0.
// - Watchdog period selects 0.5/1/5/30 s; any completed access restarts it.
// - Read-only role field reports standalone, slave or master.
// - Two-bit dither field selects nominal, +10%, -10% or spread.
// - Three bits disable connector, battery and die temperature guards.
`timescale 1ns/1ps
`default_nettype none
module cscr_top #(
  parameter int WD_CYC0 = cscr_pkg::WD_MS0 * cscr_pkg::CLK_KHZ,
  parameter int WD_CYC1 = cscr_pkg::WD_MS1 * cscr_pkg::CLK_KHZ,
  parameter int WD_CYC2 = cscr_pkg::WD_MS2 * cscr_pkg::CLK_KHZ,
  parameter int WD_CYC3 = cscr_pkg::WD_MS3 * cscr_pkg::CLK_KHZ,
  parameter int SS_CYC0 = cscr_pkg::SS_MS0 * cscr_pkg::CLK_KHZ,
  parameter int SS_CYC1 = cscr_pkg::SS_MS1 * cscr_pkg::CLK_KHZ,
  parameter int SS_CYC2 = cscr_pkg::SS_MS2 * cscr_pkg::CLK_KHZ,
  parameter int SS_CYC3 = cscr_pkg::SS_MS3 * cscr_pkg::CLK_KHZ
) (
  // Core clock and reset
  input  wire logic                CORE_CLK,
  input  wire logic                RSTN,
  // Link clock domain register port
  input  wire logic                LINK_CLK,
  input  wire logic                LINK_RSTN,
  input  wire logic                LINK_REQ,
  input  wire cscr_pkg::cscr_req_s LINK_CMD,
  output logic                     LINK_BUSY,
  output logic                     LINK_ACK,
  output logic [7:0]               LINK_RDATA,
  // Analog status and straps
  input  wire cscr_pkg::cscr_sense_s SENSE,
  input  wire logic [1:0]          ROLE_PINS,
  input  wire logic [1:0]          SS_TMO_SEL,
  // Converter control
  output logic                     INT_N,
  output logic                     CONV_RUN,
  output logic                     DIAG_START,
  output logic [2:0]               FSW_CODE,
  output logic [1:0]               DITHER_SEL,
  output logic                     CHARGE_ON,
  output logic [2:0]               GUARD_OFF
);
  // Counters compare against limit minus one, so a limit below 2 cannot be served
  if (WD_CYC0 < 2 || WD_CYC1 < 2 || WD_CYC2 < 2 || WD_CYC3 < 2 ||
      SS_CYC0 < 2 || SS_CYC1 < 2 || SS_CYC2 < 2 || SS_CYC3 < 2) begin : g_bad_timing
    $error("cscr_top: timing counts must be at least 2");
  end

  function automatic logic [31:0] pick4(input logic [1:0] s, input int a, input int b, input int c, input int d);
    logic [31:0] r;
    r = 32'(a);
    unique case (s)
      2'h0: r = 32'(a);
      2'h1: r = 32'(b);
      2'h2: r = 32'(c);
      2'h3: r = 32'(d);
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: hold the command, toggle a request, wait for the answer
  cscr_pkg::cscr_req_s hold_reg;
  logic       req_tgl_reg, lbusy_reg, lack_reg;
  logic [7:0] lrdata_reg;
  logic       ack_s1_reg, ack_s2_reg, ack_s3_reg, ack_seen_reg;
  logic       ack_tgl_reg;
  logic [7:0] rdata_reg;
  wire        link_take = LINK_REQ && !lbusy_reg;
  wire        ack_evt   = (ack_s2_reg == ack_s3_reg) && (ack_s3_reg != ack_seen_reg);

  always_ff @(posedge LINK_CLK) begin
    if (!LINK_RSTN) begin
      hold_reg     <= '0;
      req_tgl_reg  <= 1'b0;
      lbusy_reg    <= 1'b0;
      lack_reg     <= 1'b0;
      lrdata_reg   <= 8'h00;
      ack_s1_reg   <= 1'b0;
      ack_s2_reg   <= 1'b0;
      ack_s3_reg   <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
      lack_reg   <= ack_evt;
      if (link_take) begin
        hold_reg    <= LINK_CMD;
        req_tgl_reg <= !req_tgl_reg;
        lbusy_reg   <= 1'b1;
      end else if (ack_evt) begin
        lbusy_reg <= 1'b0;
      end
      if (ack_evt) begin
        ack_seen_reg <= ack_s3_reg;
        lrdata_reg   <= rdata_reg;  // Stable: written on the same edge that toggled the answer
      end
    end
  end
  assign LINK_BUSY  = lbusy_reg;
  assign LINK_ACK   = lack_reg;
  assign LINK_RDATA = lrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain input synchronisers
  logic req_s1_reg, req_s2_reg, req_s3_reg, req_seen_reg;
  logic [7:0] in_s1_reg, in_s2_reg, in_s3_reg, in_st_reg;
  cscr_pkg::cscr_sense_s sns, sns_prev;
  logic [1:0] role;
  wire req_evt = (req_s2_reg == req_s3_reg) && (req_s3_reg != req_seen_reg);

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      req_s1_reg   <= 1'b0;
      req_s2_reg   <= 1'b0;
      req_s3_reg   <= 1'b0;
      req_seen_reg <= 1'b0;
      in_s1_reg    <= 8'h00;
      in_s2_reg    <= 8'h00;
      in_s3_reg    <= 8'h00;
      in_st_reg    <= 8'h00;
      sns_prev     <= '0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      if (req_evt)
        req_seen_reg <= req_s3_reg;
      in_s1_reg <= {ROLE_PINS, SENSE};
      in_s2_reg <= in_s1_reg;
      in_s3_reg <= in_s2_reg;
      if (in_s2_reg == in_s3_reg)
        in_st_reg <= in_s3_reg;
      sns_prev <= sns;
    end
  end
  assign sns  = in_st_reg[5:0];
  assign role = in_st_reg[7:6];

  wire therm_rise = sns.therm && !sns_prev.therm;
  wire ocp_rise   = sns.ocp && !sns_prev.ocp;
  wire diag_rise  = sns.diag_fail && !sns_prev.diag_fail;

  ////////////////////////////////////////////////////////////////////////////
  // Register access decode
  cscr_pkg::cscr_req_s cmd;
  assign cmd = hold_reg;  // Held stable while the request is in flight
  wire acc_wr     = req_evt && cmd.write;
  wire acc_rd     = req_evt && !cmd.write;
  wire hit_cond   = cmd.addr == cscr_pkg::ADDR_COND;
  wire hit_devctl = cmd.addr == cscr_pkg::ADDR_DEVCTL;
  wire hit_chgcfg = cmd.addr == cscr_pkg::ADDR_CHGCFG;
  wire rd_cond    = acc_rd && hit_cond;
  wire rd_devctl  = acc_rd && hit_devctl;
  wire wr_devctl  = acc_wr && hit_devctl;
  wire wr_chgcfg  = acc_wr && hit_chgcfg;
  wire reg_rst    = wr_devctl && cmd.wdata[cscr_pkg::DEVCTL_REG_RST];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [2:0] fsw_reg;
  logic       wd_off_reg;
  logic [1:0] wd_per_reg;
  logic       chg_on_reg;
  logic [1:0] dither_reg;
  logic [2:0] guard_reg;
  logic       wd_expire;
  wire  [7:0] dev_rst = cscr_pkg::DEVCTL_RESET;
  wire  [7:0] chg_rst = cscr_pkg::CHGCFG_RESET;
  wire        chg_on_write = wr_chgcfg && cmd.wdata[cscr_pkg::CHG_ON_BIT];

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      fsw_reg    <= dev_rst[cscr_pkg::DEVCTL_FSW_LSB +: 3];
      wd_off_reg <= dev_rst[cscr_pkg::DEVCTL_WD_OFF];
      wd_per_reg <= dev_rst[cscr_pkg::DEVCTL_WD_LSB +: 2];
      chg_on_reg <= chg_rst[cscr_pkg::CHG_ON_BIT];
      dither_reg <= chg_rst[cscr_pkg::CHG_DITHER_LSB +: 2];
      guard_reg  <= chg_rst[cscr_pkg::CHG_GUARD_LSB +: 3];
    end else begin
      if (wr_devctl)
        fsw_reg <= cmd.wdata[cscr_pkg::DEVCTL_FSW_LSB +: 3];
      if (reg_rst) begin
        wd_off_reg <= dev_rst[cscr_pkg::DEVCTL_WD_OFF];
        wd_per_reg <= dev_rst[cscr_pkg::DEVCTL_WD_LSB +: 2];
        chg_on_reg <= chg_rst[cscr_pkg::CHG_ON_BIT];
        dither_reg <= chg_rst[cscr_pkg::CHG_DITHER_LSB +: 2];
        guard_reg  <= chg_rst[cscr_pkg::CHG_GUARD_LSB +: 3];
      end else begin
        if (wr_devctl) begin
          wd_off_reg <= cmd.wdata[cscr_pkg::DEVCTL_WD_OFF];
          wd_per_reg <= cmd.wdata[cscr_pkg::DEVCTL_WD_LSB +: 2];
        end
        if (wr_chgcfg) begin
          chg_on_reg <= cmd.wdata[cscr_pkg::CHG_ON_BIT];
          dither_reg <= cmd.wdata[cscr_pkg::CHG_DITHER_LSB +: 2];
          guard_reg  <= cmd.wdata[cscr_pkg::CHG_GUARD_LSB +: 3];
        end else if (wd_expire) begin
          chg_on_reg <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: any completed access restarts it
  logic [31:0] wd_cnt_reg;
  wire  [31:0] wd_lim = pick4(wd_per_reg, WD_CYC0, WD_CYC1, WD_CYC2, WD_CYC3);
  assign wd_expire = !wd_off_reg && !req_evt && (wd_cnt_reg == wd_lim - 32'h1);

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN)
      wd_cnt_reg <= 32'h0;
    else if (wd_off_reg || req_evt || wd_expire)
      wd_cnt_reg <= 32'h0;
    else
      wd_cnt_reg <= wd_cnt_reg + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter sequencing and soft-start supervision
  cscr_pkg::cscr_conv_e st_reg, st_next;
  logic [31:0] ss_cnt_reg;
  wire  [31:0] ss_lim   = pick4(SS_TMO_SEL, SS_CYC0, SS_CYC1, SS_CYC2, SS_CYC3);
  wire         stop_c   = !chg_on_reg || sns.low || sns.high || sns.therm;
  wire         ss_tmo   = (st_reg == cscr_pkg::CONV_SOFT) && !stop_c && !sns.ucp_ok &&
                          (ss_cnt_reg == ss_lim - 32'h1);
  wire         sw_start = (st_reg == cscr_pkg::CONV_IDLE) && !stop_c;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      cscr_pkg::CONV_IDLE: if (!stop_c) st_next = cscr_pkg::CONV_SOFT;
      cscr_pkg::CONV_SOFT: begin
        if (stop_c)
          st_next = cscr_pkg::CONV_IDLE;
        else if (sns.ucp_ok)
          st_next = cscr_pkg::CONV_RUN;
        else if (ss_tmo)
          st_next = cscr_pkg::CONV_HALT;
      end
      cscr_pkg::CONV_RUN:  if (stop_c) st_next = cscr_pkg::CONV_IDLE;
      // A timed-out start stays halted until charging is switched off
      cscr_pkg::CONV_HALT: if (!chg_on_reg) st_next = cscr_pkg::CONV_IDLE;
    endcase
  end

  logic run_reg, diag_reg;
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      st_reg     <= cscr_pkg::CONV_IDLE;
      ss_cnt_reg <= 32'h0;
      run_reg    <= 1'b0;
      diag_reg   <= 1'b0;
    end else begin
      st_reg     <= st_next;
      ss_cnt_reg <= (st_next == cscr_pkg::CONV_SOFT && st_reg == cscr_pkg::CONV_SOFT) ? ss_cnt_reg + 32'h1 : 32'h0;
      run_reg    <= (st_next == cscr_pkg::CONV_SOFT) || (st_next == cscr_pkg::CONV_RUN);
      diag_reg   <= chg_on_write && !chg_on_reg && !reg_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags: a new event wins over the clear of a read or a reset
  logic therm_f_reg, ss_f_reg, ocp_f_reg, diag_f_reg, wd_f_reg;
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      therm_f_reg <= 1'b0;
      ss_f_reg    <= 1'b0;
      ocp_f_reg   <= 1'b0;
      diag_f_reg  <= 1'b0;
      wd_f_reg    <= 1'b0;
    end else begin
      therm_f_reg <= therm_rise || (therm_f_reg && !rd_cond && !reg_rst);
      ss_f_reg    <= ss_tmo || (ss_f_reg && !rd_cond);
      ocp_f_reg   <= ocp_rise || (ocp_f_reg && !rd_cond);
      diag_f_reg  <= diag_rise || (diag_f_reg && !rd_cond && !reg_rst);
      wd_f_reg    <= wd_expire || (wd_f_reg && !rd_devctl && !reg_rst);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, answer toggle, interrupt pulse and outputs
  wire [7:0] cond_val   = {therm_f_reg, sns.therm, sns.low, sns.high, ss_f_reg, run_reg, ocp_f_reg, diag_f_reg};
  wire [7:0] devctl_val = {1'b0, fsw_reg, wd_f_reg, wd_off_reg, wd_per_reg};
  wire [7:0] chgcfg_val = {chg_on_reg, role, dither_reg, guard_reg};
  wire [7:0] rd_mux     = hit_cond ? cond_val : hit_devctl ? devctl_val : hit_chgcfg ? chgcfg_val : 8'h00;
  wire       int_evt    = therm_rise || ss_tmo || ocp_rise || diag_rise || wd_expire || sw_start;
  wire [2:0] fsw_eff    = (role != cscr_pkg::ROLE_ALONE && fsw_reg > cscr_pkg::FSW_CAP) ? cscr_pkg::FSW_CAP : fsw_reg;
  logic [15:0] int_cnt_reg;
  wire  [15:0] int_cnt_next = int_evt ? 16'(cscr_pkg::INT_PULSE_CYC) :
                              (int_cnt_reg != 16'h0) ? int_cnt_reg - 16'h1 : 16'h0;
  logic int_n_reg;
  logic [2:0] fsw_o_reg;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rdata_reg   <= 8'h00;
      ack_tgl_reg <= 1'b0;
      int_cnt_reg <= 16'h0;
      int_n_reg   <= 1'b1;
      fsw_o_reg   <= dev_rst[cscr_pkg::DEVCTL_FSW_LSB +: 3];
    end else begin
      if (req_evt) begin
        rdata_reg   <= cmd.write ? 8'h00 : rd_mux;
        ack_tgl_reg <= !ack_tgl_reg;
      end
      int_cnt_reg <= int_cnt_next;
      int_n_reg   <= int_cnt_next == 16'h0;
      fsw_o_reg   <= fsw_eff;
    end
  end

  assign INT_N      = int_n_reg;
  assign CONV_RUN   = run_reg;
  assign DIAG_START = diag_reg;
  assign FSW_CODE   = fsw_o_reg;
  assign DITHER_SEL = dither_reg;
  assign CHARGE_ON  = chg_on_reg;
  assign GUARD_OFF  = guard_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  therm_flag_a: assert property (therm_rise |=> therm_f_reg && !INT_N)
    else $error("thermal trip flag or interrupt missing");
  therm_live_a: assert property (rd_cond |=> rdata_reg[cscr_pkg::COND_THERM_LIVE] == $past(sns.therm))
    else $error("thermal live bit wrong on read");
  low_stop_a: assert property (sns.low |=> !run_reg)
    else $error("running while input too low");
  high_stop_a: assert property (sns.high |=> !run_reg)
    else $error("running while input too high");
  ss_halt_a: assert property (ss_tmo |=> ss_f_reg && !run_reg && st_reg == cscr_pkg::CONV_HALT)
    else $error("soft-start timeout not handled");
  start_int_a: assert property (sw_start |=> run_reg && !INT_N)
    else $error("switching start without interrupt");
  ocp_flag_a: assert property (ocp_rise |=> ocp_f_reg ##1 !INT_N)
    else $error("current limit flag missing");
  diag_start_a: assert property (chg_on_write && !chg_on_reg && !reg_rst |=> DIAG_START ##1 !DIAG_START)
    else $error("pin check not started once");
  reg_rst_a: assert property (reg_rst |=> !CHARGE_ON && !wd_off_reg && wd_per_reg == 2'h0 && GUARD_OFF == 3'h0)
    else $error("register reset incomplete");
  fsw_cap_a: assert property (role != cscr_pkg::ROLE_ALONE && $stable(role) |=> FSW_CODE <= cscr_pkg::FSW_CAP)
    else $error("frequency not capped");
  wd_exp_a: assert property (wd_expire |=> wd_f_reg && !CHARGE_ON && $stable(GUARD_OFF))
    else $error("watchdog expiry not handled");
  wd_off_a: assert property (wd_off_reg |-> !wd_expire ##1 wd_cnt_reg == 32'h0)
    else $error("watchdog runs while off");
  read_set_a: assert property (rd_cond && ocp_rise |=> ocp_f_reg)
    else $error("event lost during read");

  start_c: cover property (sw_start ##[1:50] st_reg == cscr_pkg::CONV_RUN);
  tmo_c:   cover property (ss_tmo);
  wd_c:    cover property (wd_expire);
  read_c:  cover property (rd_cond && ocp_f_reg);
endmodule // cscr_top
`default_nettype wire

// ==== sim/cscr_adapter_model.sv ====
// Adapter and output-pin model on the converter's far side
`timescale 1ns/1ps
`default_nettype none
module cscr_adapter_model #(
  parameter int RAMP_CYC = 40
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Converter side
  input  wire logic conv_run,
  input  wire logic diag_start,
  // Scenario controls
  input  wire logic slow,
  input  wire logic pins_bad,
  // Sense returns
  output logic      ucp_ok,
  output logic      diag_fail
);
  int ramp_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Current ramps only while switching; a slow adapter never gets there
  always @(negedge clk) begin
    if (!rstn || !conv_run) begin
      ramp_cnt <= 0;
      ucp_ok   <= 1'b0;
    end else begin
      ramp_cnt <= ramp_cnt + 1;
      ucp_ok   <= !slow && (ramp_cnt >= RAMP_CYC);
    end
    if (!rstn) begin
      diag_fail <= 1'b0;
    end else if (diag_start) begin
      diag_fail <= pins_bad;
    end
  end
endmodule // cscr_adapter_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the converter status and control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] A_C = cscr_pkg::ADDR_COND;
  localparam logic [7:0] A_D = cscr_pkg::ADDR_DEVCTL;
  localparam logic [7:0] A_G = cscr_pkg::ADDR_CHGCFG;
  localparam int         WD0 = 2000;
  logic                  core_clk = 1'b0, link_clk = 1'b0, rstn = 1'b0, link_rstn = 1'b0, link_req = 1'b0;
  cscr_pkg::cscr_req_s   link_cmd = '0;
  cscr_pkg::cscr_sense_s sense;
  logic                  therm = 1'b0, low = 1'b0, high = 1'b0, ocp = 1'b0, slow = 1'b0, pins_bad = 1'b0;
  logic [1:0]            role_pins = 2'h0, ss_sel = 2'h1;
  logic                  link_busy, link_ack, int_n, conv_run, diag_start, charge_on, ucp_ok, diag_fail;
  logic [7:0]            link_rdata, rd;
  logic [2:0]            fsw_code, guard_off;
  logic [1:0]            dither_sel;
  logic                  int_q = 1'b1;
  int                    err_total = 0, check_count = 0, int_falls = 0;
  assign sense = {therm, low, high, ocp, ucp_ok, diag_fail};
  always #10 core_clk = ~core_clk;
  // Link clock offset so its edges never line up with the core clock
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end
  always @(posedge core_clk) begin
    int_q <= int_n;
    if (int_q === 1'b1 && int_n === 1'b0) int_falls++;
  end
  ////////////////////////////////////////////////////////////////////////////
  // The periods the scenarios select are shortened, plus the second watchdog period, which no scenario selects
  cscr_top #(.WD_CYC0(WD0), .WD_CYC1(3000), .SS_CYC1(150)) dut_u (
    .CORE_CLK(core_clk), .RSTN(rstn), .LINK_CLK(link_clk), .LINK_RSTN(link_rstn),
    .LINK_REQ(link_req), .LINK_CMD(link_cmd), .LINK_BUSY(link_busy), .LINK_ACK(link_ack),
    .LINK_RDATA(link_rdata), .SENSE(sense), .ROLE_PINS(role_pins), .SS_TMO_SEL(ss_sel),
    .INT_N(int_n), .CONV_RUN(conv_run), .DIAG_START(diag_start), .FSW_CODE(fsw_code),
    .DITHER_SEL(dither_sel), .CHARGE_ON(charge_on), .GUARD_OFF(guard_off));
  cscr_adapter_model adapter_u (.clk(core_clk), .rstn(rstn), .conv_run(conv_run), .diag_start(diag_start),
    .slow(slow), .pins_bad(pins_bad), .ucp_ok(ucp_ok), .diag_fail(diag_fail));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // One strobe per access, then a bounded wait for the answer
  task automatic acc(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    int n;
    @(negedge link_clk);
    link_req = 1'b1;
    link_cmd = {wr, addr, wd};
    @(negedge link_clk);
    link_req = 1'b0;
    chk8("access busy", 8'h01, {7'h0, link_busy});
    for (n = 0; n < 20 && link_ack !== 1'b1; n++) @(negedge link_clk);
    chk8("access ack", 8'h01, {7'h0, link_ack});
    rd = link_rdata;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] wd);
    acc(1'b1, addr, wd);
    cyc(4);
  endtask
  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp, input string what);
    acc(1'b0, addr, 8'h00);
    chk8(what, exp, rd);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    $display("[FAIL] run length expected finish seen timeout");
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin : main
    int i;
    int f0;
    // Link reset needs several slow-clock edges, so both are held in link cycles
    repeat (16) @(negedge link_clk);
    rstn = 1'b1;
    link_rstn = 1'b1;
    repeat (4) @(negedge link_clk);
    rdc(A_D, 8'h40, "devctl reset");
    rdc(A_G, 8'h00, "chgcfg reset");
    rdc(A_C, 8'h00, "cond reset");
    rdc(8'h0D, 8'h00, "unmapped read");
    chk8("fsw reset", 8'h04, {5'h0, fsw_code});
    $display("test defaults done");
    for (i = 0; i < 8; i++) begin
      wr(A_D, {1'b0, i[2:0], 4'h4});
      chk8("fsw code", {5'h0, i[2:0]}, {5'h0, fsw_code});
      rdc(A_D, {1'b0, i[2:0], 4'h4}, "fsw readback");
    end
    for (i = 1; i < 4; i++) begin
      cyc(1);
      role_pins = i[1:0];
      cyc(10);
      rdc(A_G, {1'b0, i[1:0], 5'h0}, "role field");
      wr(A_D, 8'h74);
      chk8("fsw capped", 8'h04, {5'h0, fsw_code});
    end
    cyc(1);
    role_pins = 2'h0;
    cyc(10);
    chk8("fsw uncapped", 8'h07, {5'h0, fsw_code});
    $display("test frequency and role done");
    for (i = 0; i < 8; i++) begin
      wr(A_G, {3'h0, i[1:0], i[2:0]});
      chk8("dither", {6'h0, i[1:0]}, {6'h0, dither_sel});
      chk8("guards", {5'h0, i[2:0]}, {5'h0, guard_off});
      rdc(A_G, {3'h0, i[1:0], i[2:0]}, "chgcfg readback");
    end
    $display("test dither and guards done");
    cyc(1);
    therm = 1'b1;
    cyc(10);
    chk8("int on thermal", 8'h00, {7'h0, int_n});
    rdc(A_C, 8'hC0, "thermal flag and live");
    rdc(A_C, 8'h40, "thermal after read");
    therm = 1'b0;
    low = 1'b1;
    cyc(10);
    rdc(A_C, 8'h20, "input too low");
    low = 1'b0;
    high = 1'b1;
    cyc(10);
    rdc(A_C, 8'h10, "input too high");
    high = 1'b0;
    ocp = 1'b1;
    cyc(10);
    ocp = 1'b0;
    rdc(A_C, 8'h02, "current limit flag");
    rdc(A_C, 8'h00, "current limit cleared");
    $display("test status done");
    slow = 1'b1;
    wr(A_G, 8'h80);
    cyc(80);
    chk8("soft start running", 8'h01, {7'h0, conv_run});
    cyc(60);
    chk8("soft start halted", 8'h00, {7'h0, conv_run});
    rdc(A_C, 8'h08, "soft start flag");
    rdc(A_C, 8'h00, "soft start cleared");
    wr(A_G, 8'h00);
    slow = 1'b0;
    pins_bad = 1'b1;
    for (i = 0; i < 4000 && int_n !== 1'b1; i++) cyc(1);
    f0 = int_falls;
    wr(A_G, 8'h80);
    cyc(200);
    chk8("start interrupts", 8'h01, 8'(int_falls - f0));
    chk8("converter running", 8'h01, {7'h0, conv_run});
    rdc(A_C, 8'h05, "running and pin fail");
    rdc(A_C, 8'h04, "running live");
    $display("test converter done");
    wr(A_G, 8'h98);
    wr(A_D, 8'h40);
    for (i = 0; i < 4; i++) begin
      cyc(1000);
      rdc(A_G, 8'h98, "charge kept by access");
    end
    cyc(WD0 + 300);
    chk8("charge dropped", 8'h00, {7'h0, charge_on});
    rdc(A_D, 8'h48, "watchdog flag");
    rdc(A_D, 8'h40, "watchdog flag cleared");
    rdc(A_G, 8'h18, "charge off others kept");
    wr(A_D, 8'h44);
    wr(A_G, 8'h80);
    cyc(5000);
    chk8("watchdog off", 8'h01, {7'h0, charge_on});
    $display("test watchdog done");
    wr(A_D, 8'h34);
    wr(A_G, 8'h1F);
    // The reset write carries the frequency field too, so it repeats the current code
    wr(A_D, 8'hB0);
    rdc(A_D, 8'h30, "register reset devctl");
    rdc(A_G, 8'h00, "register reset chgcfg");
    chk8("fsw kept", 8'h03, {5'h0, fsw_code});
    $display("test register reset done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
